// *** logic/asr_map.svh ***
// timing constants and pin encodings for the static memory host port
`ifndef ASR_MAP_SVH
`define ASR_MAP_SVH
`define ASR_CLK_PERIOD_NS   100
`define ASR_ACCESS_MAX_NS   15
`define ASR_LANE_ACCESS_NS  8
`define ASR_OFF_MAX_NS      8
`define ASR_END_WRITE_NS    12
`define ASR_DATA_SETUP_NS   8
`define ASR_SYNC_CYCLES     3
// least times round up, never below one cycle
`define ASR_CYC_UP(ns) ((((ns) + `ASR_CLK_PERIOD_NS - 1) / `ASR_CLK_PERIOD_NS) < 1 ? 1 : \
  (((ns) + `ASR_CLK_PERIOD_NS - 1) / `ASR_CLK_PERIOD_NS))
`define ASR_RD_CYCLES  (`ASR_CYC_UP(`ASR_ACCESS_MAX_NS) + 1)
`define ASR_WR_CYCLES  `ASR_CYC_UP(`ASR_END_WRITE_NS)
`define ASR_TURN_CYCLES `ASR_CYC_UP(`ASR_OFF_MAX_NS)
`define ASR_PIN_OFF    1'b1
`define ASR_PIN_ON     1'b0
`define ASR_CNT_ZERO   4'h0
`endif

// *** logic/asr_pkg.sv ***
// types shared by the static memory host port
package asr_pkg;
  typedef enum logic [2:0] {ASR_IDLE, ASR_RD_SETUP, ASR_RD_WAIT, ASR_WR_PULSE,
                            ASR_WR_HOLD, ASR_TURN} asr_state_t;
  typedef logic [17:0] asr_addr_t;
  typedef logic [15:0] asr_data_t;
endpackage

// *** logic/asr_sync.sv ***
// three-stage synchroniser for the returning data lines
`timescale 1ns/1ns
`include "asr_map.svh"
module asr_sync #(
  parameter int W = 16
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_stable
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] held_q;
  // the first stage feeds only the second; a change counts once stages two and three agree
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      held_q <= '0;
    end
    else
    begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int b = 0; b < W; b++)
        if (s2_q[b] == s3_q[b]) held_q[b] <= s3_q[b];
    end
  end
  assign o_stable = held_q;
endmodule

// *** logic/asr_host.sv ***
// host-side sequencer driving an asynchronous 16-bit static memory with byte lanes
`timescale 1ns/1ns
`include "asr_map.svh"
module asr_host
(
  input  wire logic             I_SYS_CLK,
  input  wire logic             I_RESET_N,
  input  wire logic             i_req,
  input  wire logic             i_write,
  input  wire asr_pkg::asr_addr_t i_addr,
  input  wire asr_pkg::asr_data_t i_wdata,
  input  wire logic [1:0]       i_lanes,
  input  wire asr_pkg::asr_data_t i_data_lines,
  output logic                  o_busy,
  output logic                  o_done,
  output asr_pkg::asr_data_t    o_rdata,
  output asr_pkg::asr_addr_t    o_word_address,
  output logic                  o_chip_sel_n,
  output logic                  o_out_en_n,
  output logic                  o_write_n,
  output logic                  o_low_lane_sel_n,
  output logic                  o_high_lane_sel_n,
  output asr_pkg::asr_data_t    o_data_lines,
  output logic                  o_data_lines_oe,
  output logic                  o_unused_input
);
  import asr_pkg::*;
  // ****************************************
  // state and pin registers
  // ****************************************
  asr_state_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  asr_addr_t  addr_q;
  asr_data_t  wdata_q, rdata_q;
  logic       wr_q, busy_q, done_q, cs_n_q, oe_n_q, we_n_q, lb_n_q, ub_n_q, doe_q;
  logic [1:0] lanes_q;
  asr_data_t  data_sync;

  // data from the pins crosses into the clock domain first
  asr_sync #(.W(16)) u_sync (
    .i_clk    (I_SYS_CLK),
    .i_rst_n  (I_RESET_N),
    .i_async  (i_data_lines),
    .o_stable (data_sync)
  );

  // ****************************************
  // decode
  // ****************************************
  wire       start    = i_req && !busy_q;
  wire       cnt_zero = (cnt_q == `ASR_CNT_ZERO);
  // empty lane mask would be an outputs-disabled cycle; treat it as both lanes
  wire [1:0] lanes_in = (i_lanes == 2'h0) ? 2'h3 : i_lanes;
  // sampling stage adds three cycles of synchroniser delay to the access wait
  wire [3:0] rd_wait  = 4'(`ASR_RD_CYCLES + `ASR_SYNC_CYCLES);
  // merge only enabled lanes into the read word
  wire asr_data_t rd_merge = {lanes_q[1] ? data_sync[15:8] : rdata_q[15:8],
                              lanes_q[0] ? data_sync[7:0]  : rdata_q[7:0]};

  // next-state logic
  always_comb
  begin
    st_d  = st_q;
    cnt_d = cnt_zero ? cnt_q : cnt_q - 4'h1;
    unique case (st_q)
      ASR_IDLE:
        if (start)
        begin
          st_d  = i_write ? ASR_WR_PULSE : ASR_RD_SETUP;
          cnt_d = i_write ? 4'(`ASR_WR_CYCLES) : rd_wait;
        end
      ASR_RD_SETUP: st_d = ASR_RD_WAIT;
      ASR_RD_WAIT:  if (cnt_zero) st_d = ASR_TURN;
      ASR_WR_PULSE: if (cnt_zero) st_d = ASR_WR_HOLD;
      ASR_WR_HOLD:  st_d = ASR_TURN;
      ASR_TURN:
        if (cnt_zero && !wr_q) st_d = ASR_IDLE;
        else if (wr_q) st_d = ASR_IDLE;
      // unused state codes fall back to idle
      default: st_d = ASR_IDLE;
    endcase
    if (st_q == ASR_RD_WAIT && cnt_zero) cnt_d = 4'(`ASR_TURN_CYCLES);
  end

  // ****************************************
  // sequencer and pin drivers
  // ****************************************
  // all pins but the tied-low unused input come from flops so no glitch reaches the memory
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      st_q    <= ASR_IDLE;
      cnt_q   <= `ASR_CNT_ZERO;
      addr_q  <= '0;
      wdata_q <= '0;
      rdata_q <= '0;
      wr_q    <= 1'b0;
      lanes_q <= 2'h0;
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
      cs_n_q  <= `ASR_PIN_OFF;
      oe_n_q  <= `ASR_PIN_OFF;
      we_n_q  <= `ASR_PIN_OFF;
      lb_n_q  <= `ASR_PIN_OFF;
      ub_n_q  <= `ASR_PIN_OFF;
      doe_q   <= 1'b0;
    end
    else
    begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      done_q <= 1'b0;
      unique case (st_q)
        ASR_IDLE:
          if (start)
          begin
            // address, lanes and select go first so they lead the write strobe
            addr_q  <= i_addr;
            wdata_q <= i_wdata;
            wr_q    <= i_write;
            lanes_q <= lanes_in;
            busy_q  <= 1'b1;
            cs_n_q  <= `ASR_PIN_ON;
            lb_n_q  <= lanes_in[0] ? `ASR_PIN_ON : `ASR_PIN_OFF;
            ub_n_q  <= lanes_in[1] ? `ASR_PIN_ON : `ASR_PIN_OFF;
            we_n_q  <= `ASR_PIN_OFF;
            oe_n_q  <= `ASR_PIN_OFF;
          end
        ASR_RD_SETUP:
          oe_n_q <= `ASR_PIN_ON;
        ASR_WR_PULSE:
        begin
          // strobe falls a cycle after select; out enable stays high so the memory never turns its outputs on
          we_n_q <= `ASR_PIN_ON;
          doe_q  <= 1'b1;
        end
        ASR_WR_HOLD:
          we_n_q <= `ASR_PIN_OFF;
        ASR_RD_WAIT:
          if (cnt_zero)
          begin
            rdata_q <= rd_merge;
            oe_n_q  <= `ASR_PIN_OFF;
            cs_n_q  <= `ASR_PIN_OFF;
            lb_n_q  <= `ASR_PIN_OFF;
            ub_n_q  <= `ASR_PIN_OFF;
          end
        ASR_TURN:
        begin
          // select, lanes and data drop one cycle after the strobe rises
          cs_n_q <= `ASR_PIN_OFF;
          lb_n_q <= `ASR_PIN_OFF;
          ub_n_q <= `ASR_PIN_OFF;
          doe_q  <= 1'b0;
          if (st_d == ASR_IDLE)
          begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end
        end
      endcase
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign o_busy            = busy_q;
  assign o_done            = done_q;
  assign o_rdata           = rdata_q;
  assign o_word_address    = addr_q;
  assign o_chip_sel_n      = cs_n_q;
  assign o_out_en_n        = oe_n_q;
  assign o_write_n         = we_n_q;
  assign o_low_lane_sel_n  = lb_n_q;
  assign o_high_lane_sel_n = ub_n_q;
  assign o_data_lines      = wdata_q;
  assign o_data_lines_oe   = doe_q;
  assign o_unused_input    = 1'b0;  // must sit low, never above the low input level
endmodule

// *** verif/asr_host_checker.sv ***
// pin-level assertions for the static memory host port
`timescale 1ns/1ns
module asr_host_checker
(
  input wire logic              I_SYS_CLK,
  input wire logic              I_RESET_N,
  input wire logic              i_req,
  input wire logic              i_write,
  input wire logic              o_busy,
  input wire logic              o_done,
  input wire asr_pkg::asr_addr_t o_word_address,
  input wire logic              o_chip_sel_n,
  input wire logic              o_out_en_n,
  input wire logic              o_write_n,
  input wire logic              o_low_lane_sel_n,
  input wire logic              o_high_lane_sel_n,
  input wire logic              o_data_lines_oe
);
  import asr_pkg::*;
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RESET_N);
  // strobe may only fall inside a selected cycle, and ends before the select does
  rd_strobe_high_a: assert property (!o_out_en_n |-> o_write_n)
    else $error("write strobe low during read");
  wr_sel_hold_a: assert property ($rose(o_write_n) |-> !o_chip_sel_n && $past(!o_chip_sel_n))
    else $error("select dropped with write strobe");
  wr_lane_hold_a: assert property (!o_write_n |=>
    $stable({o_low_lane_sel_n, o_high_lane_sel_n}) && !(o_low_lane_sel_n && o_high_lane_sel_n))
    else $error("lane controls moved at write end");
  wr_addr_hold_a: assert property (!o_write_n |-> $past(!o_chip_sel_n) ##1 $stable(o_word_address))
    else $error("address unstable around write");
  // host must never drive against a reading memory
  bus_no_fight_a: assert property (o_data_lines_oe |-> o_out_en_n)
    else $error("host drives while memory outputs enabled");
  standby_quiet_a: assert property (o_chip_sel_n |-> o_write_n && o_out_en_n)
    else $error("strobe or enable active while deselected");
  wr_latency_a: assert property (i_req && !o_busy && i_write |=> o_busy ##4 o_done)
    else $error("write not finished on time");
  rd_latency_a: assert property (i_req && !o_busy && !i_write |=> o_busy ##[8:9] o_done)
    else $error("read not finished on time");
  done_pulse_a: assert property (o_done |=> !o_done)
    else $error("done longer than one cycle");
endmodule

// *** verif/asr_sram_model.sv ***
// behavioural static memory with byte lanes at slower-grade delays
`timescale 1ns/1ns
module asr_sram_model
(
  input  wire logic              i_cs_n,
  input  wire logic              i_oe_n,
  input  wire logic              i_we_n,
  input  wire logic              i_lb_n,
  input  wire logic              i_ub_n,
  input  wire asr_pkg::asr_addr_t i_addr,
  input  wire asr_pkg::asr_data_t i_din,
  output asr_pkg::asr_data_t     o_dq
);
  import asr_pkg::*;
  asr_data_t mem [0:262143];
  asr_data_t word;
  logic      rd_on;
  initial
  begin
    foreach (mem[k]) mem[k] = 16'h0000;
  end
  // outputs only with select and enable low and strobe high
  assign rd_on = !i_cs_n && !i_oe_n && i_we_n;
  assign word = mem[i_addr];
  // released lanes show the inverse so stale data never passes; worst-case delay both ways
  assign #15 o_dq = {(rd_on && !i_ub_n) ? word[15:8] : ~word[15:8],
                     (rd_on && !i_lb_n) ? word[7:0] : ~word[7:0]};
  // store on strobe rise while selected; lanes gate the bytes
  always @(posedge i_we_n)
    if (!i_cs_n)
    begin
      mem[i_addr] <= {i_ub_n ? word[15:8] : i_din[15:8], i_lb_n ? word[7:0] : i_din[7:0]};
    end
endmodule

// *** verif/tb_top.sv ***
// top-level bench for the static memory host port
`timescale 1ns/1ns
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
  $display("ERROR %s expected %h seen %h", n, e, a); end end
module tb_top;
  import asr_pkg::*;
  logic      clk, rst_n, req, wr, busy, done, cs_n, oe_n, we_n, lb_n, ub_n, h_oe, nu;
  asr_addr_t addr, w_addr;
  asr_data_t wdata, dq, rdata, h_out, din;
  logic [1:0] lanes;
  int        miscompares = 0;
  int        checks_done = 0;
  // released host lines read back inverted
  assign din = h_oe ? h_out : ~h_out;
  asr_host asr_host_i (.I_SYS_CLK(clk), .I_RESET_N(rst_n), .i_req(req), .i_write(wr),
    .i_addr(addr), .i_wdata(wdata), .i_lanes(lanes), .i_data_lines(dq), .o_busy(busy),
    .o_done(done), .o_rdata(rdata), .o_word_address(w_addr), .o_chip_sel_n(cs_n),
    .o_out_en_n(oe_n), .o_write_n(we_n), .o_low_lane_sel_n(lb_n), .o_high_lane_sel_n(ub_n),
    .o_data_lines(h_out), .o_data_lines_oe(h_oe), .o_unused_input(nu));
  asr_sram_model asr_sram_model_i (.i_cs_n(cs_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_lb_n(lb_n),
    .i_ub_n(ub_n), .i_addr(w_addr), .i_din(din), .o_dq(dq));
  // one transfer; poke keeps requesting elsewhere while busy, which must be ignored
  task automatic xfer(input logic w, input asr_addr_t a, input asr_data_t d,
                      input logic [1:0] l, input logic poke);
    int n;
    @(negedge clk);
    req = 1'b1; wr = w; addr = a; wdata = d; lanes = l;
    @(negedge clk);
    req = poke; addr = a + 18'h00001; wdata = ~d;
    `CHK("busy", 1'b1, busy)
    for (n = 0; n < 20 && done !== 1'b1; n++) @(negedge clk);
    req = 1'b0;
    `CHK("done", 1'b1, done)
  endtask
  task automatic sc_full;
    xfer(1'b1, 18'h3FFFF, 16'hA5C3, 2'h3, 1'b1);
    xfer(1'b0, 18'h3FFFF, 16'h0000, 2'h3, 1'b0);
    `CHK("full word", 16'hA5C3, rdata)
    xfer(1'b0, 18'h00000, 16'h0000, 2'h3, 1'b0);
    `CHK("refused write", 16'h0000, rdata)
  endtask
  task automatic sc_lanes;
    xfer(1'b1, 18'h00010, 16'h1234, 2'h3, 1'b0);
    xfer(1'b1, 18'h00010, 16'hABCD, 2'h2, 1'b0);
    xfer(1'b1, 18'h00010, 16'hEF56, 2'h1, 1'b0);
    xfer(1'b0, 18'h00010, 16'h0000, 2'h3, 1'b0);
    `CHK("lane merge", 16'hAB56, rdata)
    xfer(1'b1, 18'h00011, 16'h9988, 2'h0, 1'b0);
    xfer(1'b0, 18'h00011, 16'h0000, 2'h2, 1'b0);
    `CHK("high lane read", 16'h9956, rdata)
    xfer(1'b0, 18'h00011, 16'h0000, 2'h0, 1'b0);
    `CHK("empty mask read", 16'h9988, rdata)
    xfer(1'b0, 18'h00010, 16'h0000, 2'h1, 1'b0);
    `CHK("low lane read", 16'h9956, rdata)
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    rst_n = 1'b0; req = 1'b0; wr = 1'b0; addr = 18'h00000; wdata = 16'h0000; lanes = 2'h3;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    sc_full;
    sc_lanes;
    `CHK("idle select", 1'b1, cs_n)
    `CHK("unused pin low", 1'b0, nu)
    end_sim;
  end
  // hang guard, well past the hundred or so cycles needed
  initial
  begin
    #200000;
    miscompares++;
    end_sim;
  end
endmodule
bind asr_host asr_host_checker asr_host_checker_i (.*);
